// file: can_event_irq_router.sv
// Event flag register, per-flag enable and line routing, two lines out.
// Assumes event conditions come from logic on ref_clk, level style.
`timescale 1ns/1ps
module can_event_irq_router #(
	parameter int unsigned NFLAG = evt_router_pkg::NUM_FLAGS
) (
	input wire logic ref_clk, // 100 MHz clock
	input wire logic sys_rst, // Sync reset, active high
	input wire logic [evt_router_pkg::ADDR_W-1:0] reg_addr, // Byte address
	input wire logic [31:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [31:0] reg_rdata, // Read data, cycle after strobe
	input wire logic [NFLAG-1:0] event_cond, // Event conditions by bit
	output logic event_out_a, // Interrupt line 0
	output logic event_out_b // Interrupt line 1
);

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	wire logic hit_flags = reg_addr == evt_router_pkg::OFS_FLAG_BITS;
	wire logic hit_enable = reg_addr == evt_router_pkg::OFS_ENABLE_MASK;
	wire logic hit_route = reg_addr == evt_router_pkg::OFS_LINE_ROUTE;
	wire logic hit_gate = reg_addr == evt_router_pkg::OFS_LINE_GATE;

	logic [NFLAG-1:0] event_flag_bits_ff;
	logic [NFLAG-1:0] event_enable_mask_ff;
	logic [NFLAG-1:0] event_line_route_ff;
	logic [1:0] line_gate_control_ff;
	logic [NFLAG-1:0] cond_prev_ff;
	logic [31:0] rdata_ff;

	// ------------------------------------------------------------
	// Event flags
	// ------------------------------------------------------------
	// Rising edge of each condition; set beats a same-cycle clear
	logic [NFLAG-1:0] rise;
	logic [NFLAG-1:0] clr_mask;
	logic [NFLAG-1:0] nxt_flags;
	wire logic clr_all = reg_wr && hit_flags;

	for (genvar g = 0; g < NFLAG; g++) begin : g_flag
		assign rise[g] = event_cond[g] & ~cond_prev_ff[g];
		assign clr_mask[g] = clr_all & reg_wdata[g];
		assign nxt_flags[g] = (event_flag_bits_ff[g] & ~clr_mask[g]) | rise[g];

		a_bit_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
			rise[g] |=> event_flag_bits_ff[g])
			else $error("flag bit did not set on rising condition");

		a_bit_clears: assert property (@(posedge ref_clk) disable iff (sys_rst)
			(clr_mask[g] && !rise[g]) |=> !event_flag_bits_ff[g])
			else $error("flag bit survived a write of one");

		a_bit_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
			(!event_flag_bits_ff[g] && !rise[g]) |=> !event_flag_bits_ff[g])
			else $error("flag bit set without a rising condition");

		a_bit_holds: assert property (@(posedge ref_clk) disable iff (sys_rst)
			(event_flag_bits_ff[g] && !clr_mask[g]) |=> event_flag_bits_ff[g])
			else $error("flag bit dropped without a clear");

		a_bit_to_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
			(event_flag_bits_ff[g] && event_enable_mask_ff[g] && !event_line_route_ff[g]
			&& line_gate_control_ff[0]) |-> event_out_a)
			else $error("qualified flag bit missing on line 0");

		a_bit_to_b: assert property (@(posedge ref_clk) disable iff (sys_rst)
			(event_flag_bits_ff[g] && event_enable_mask_ff[g] && event_line_route_ff[g]
			&& line_gate_control_ff[1]) |-> event_out_b)
			else $error("qualified flag bit missing on line 1");
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cond_prev_ff <= '0;
			event_flag_bits_ff <= evt_router_pkg::FLAGS_RST[NFLAG-1:0];
		end else begin
			cond_prev_ff <= event_cond;
			event_flag_bits_ff <= nxt_flags;
		end
	end

	// ------------------------------------------------------------
	// Named event flags
	// ------------------------------------------------------------
	wire logic rxq0_new_flag = event_flag_bits_ff[evt_router_pkg::BIT_RXQ0_NEW];
	wire logic rxq0_level_flag = event_flag_bits_ff[evt_router_pkg::BIT_RXQ0_LEVEL];
	wire logic rxq0_full_flag = event_flag_bits_ff[evt_router_pkg::BIT_RXQ0_FULL];
	wire logic rxq0_lost_flag = event_flag_bits_ff[evt_router_pkg::BIT_RXQ0_LOST];
	wire logic rxq1_new_flag = event_flag_bits_ff[evt_router_pkg::BIT_RXQ1_NEW];
	wire logic rxq1_level_flag = event_flag_bits_ff[evt_router_pkg::BIT_RXQ1_LEVEL];
	wire logic rxq1_full_flag = event_flag_bits_ff[evt_router_pkg::BIT_RXQ1_FULL];
	wire logic rxq1_lost_flag = event_flag_bits_ff[evt_router_pkg::BIT_RXQ1_LOST];
	wire logic urgent_msg_flag = event_flag_bits_ff[evt_router_pkg::BIT_URGENT_MSG];
	wire logic send_done_flag = event_flag_bits_ff[evt_router_pkg::BIT_SEND_DONE];
	wire logic cancel_done_flag = event_flag_bits_ff[evt_router_pkg::BIT_CANCEL_DONE];
	wire logic txq_empty_flag = event_flag_bits_ff[evt_router_pkg::BIT_TXQ_EMPTY];
	wire logic txlog_new_flag = event_flag_bits_ff[evt_router_pkg::BIT_TXLOG_NEW];
	wire logic txlog_level_flag = event_flag_bits_ff[evt_router_pkg::BIT_TXLOG_LEVEL];
	wire logic txlog_full_flag = event_flag_bits_ff[evt_router_pkg::BIT_TXLOG_FULL];
	wire logic txlog_lost_flag = event_flag_bits_ff[evt_router_pkg::BIT_TXLOG_LOST];
	wire logic stamp_wrap_flag = event_flag_bits_ff[evt_router_pkg::BIT_STAMP_WRAP];

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			event_enable_mask_ff <= evt_router_pkg::ENABLE_RST[NFLAG-1:0];
			event_line_route_ff <= evt_router_pkg::ROUTE_RST[NFLAG-1:0];
			line_gate_control_ff <= evt_router_pkg::GATE_RST;
		end else if (reg_wr) begin
			if (hit_enable) begin
				event_enable_mask_ff <= reg_wdata[NFLAG-1:0];
			end
			if (hit_route) begin
				event_line_route_ff <= reg_wdata[NFLAG-1:0];
			end
			if (hit_gate) begin
				line_gate_control_ff <= reg_wdata[1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	wire logic [31:0] rd_flags = 32'(event_flag_bits_ff);
	wire logic [31:0] rd_enable = 32'(event_enable_mask_ff);
	wire logic [31:0] rd_route = 32'(event_line_route_ff);
	wire logic [31:0] rd_gate = {30'h00000000, line_gate_control_ff};
	wire logic [31:0] nxt_rdata = hit_flags ? rd_flags :
		hit_enable ? rd_enable :
		hit_route ? rd_route :
		hit_gate ? rd_gate : 32'h00000000;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rdata_ff <= 32'h00000000;
		end else if (reg_rd) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= 32'h00000000;
		end
	end
	assign reg_rdata = rdata_ff;

	// ------------------------------------------------------------
	// Line routing
	// ------------------------------------------------------------
	wire logic [NFLAG-1:0] active = event_flag_bits_ff & event_enable_mask_ff;
	wire logic any_a = |(active & ~event_line_route_ff);
	wire logic any_b = |(active & event_line_route_ff);
	wire logic line0_gate = line_gate_control_ff[evt_router_pkg::GATE_LINE0_BIT];
	wire logic line1_gate = line_gate_control_ff[evt_router_pkg::GATE_LINE1_BIT];
	assign event_out_a = any_a & line0_gate;
	assign event_out_b = any_b & line1_gate;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_flag_sets_on_rise: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(event_cond[0] && !$past(event_cond[0])) |=> event_flag_bits_ff[0])
		else $error("flag did not set on rising condition");
	a_flag_holds: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(event_flag_bits_ff[9] && !(reg_wr && hit_flags && reg_wdata[9]))
		|=> event_flag_bits_ff[9])
		else $error("flag dropped without clear");
	a_flag_clear_w1c: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(reg_wr && hit_flags && reg_wdata[4] && !rise[4]) |=> !event_flag_bits_ff[4])
		else $error("write one did not clear flag");
	a_mask_blocks: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(event_enable_mask_ff == '0) |-> !event_out_a && !event_out_b)
		else $error("masked flag reached a line");
	a_gate_line_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!line_gate_control_ff[0] |-> !event_out_a)
		else $error("line 0 asserted while gated off");
	a_route_line_b: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(event_flag_bits_ff[15] && event_enable_mask_ff[15] && event_line_route_ff[15]
		&& line_gate_control_ff[1]) |-> event_out_b)
		else $error("routed flag missing on line 1");
	a_route_line_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(event_flag_bits_ff[16] && event_enable_mask_ff[16] && !event_line_route_ff[16]
		&& line_gate_control_ff[0]) |-> event_out_a)
		else $error("routed flag missing on line 0");
	a_enable_readback: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(reg_rd && hit_enable) |=> reg_rdata[31:30] == 2'h0
		&& reg_rdata[29:0] == $past(event_enable_mask_ff))
		else $error("enable mask readback wrong");
	a_route_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(reg_wr && hit_route) |=> event_line_route_ff == $past(reg_wdata[29:0]))
		else $error("route register not written");

	a_gate_line_b: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!line_gate_control_ff[1] |-> !event_out_b)
		else $error("line 1 asserted while gated off");

	a_line_a_or: assert property (@(posedge ref_clk) disable iff (sys_rst)
		event_out_a == ((|(event_flag_bits_ff & event_enable_mask_ff & ~event_line_route_ff))
		&& line_gate_control_ff[0]))
		else $error("line 0 differs from its qualifying flags");

	a_line_b_or: assert property (@(posedge ref_clk) disable iff (sys_rst)
		event_out_b == ((|(event_flag_bits_ff & event_enable_mask_ff & event_line_route_ff))
		&& line_gate_control_ff[1]))
		else $error("line 1 differs from its qualifying flags");

	a_route_readback: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(reg_rd && hit_route) |=> reg_rdata[31:30] == 2'h0
		&& reg_rdata[29:0] == $past(event_line_route_ff))
		else $error("route register readback wrong");

	a_gate_readback: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(reg_rd && hit_gate) |=> reg_rdata == {30'h00000000, $past(line_gate_control_ff)})
		else $error("gate register readback wrong");

	a_flags_readback: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(reg_rd && hit_flags) |=> reg_rdata[31:30] == 2'h0
		&& reg_rdata[29:0] == $past(event_flag_bits_ff))
		else $error("flag register readback wrong");

	a_rdata_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!reg_rd |=> reg_rdata == 32'h00000000)
		else $error("read data not zero without a read");

	a_unmapped_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(reg_rd && !hit_flags && !hit_enable && !hit_route && !hit_gate)
		|=> reg_rdata == 32'h00000000)
		else $error("unmapped address read nonzero");

	a_enable_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(reg_wr && hit_enable) |=> event_enable_mask_ff == $past(reg_wdata[29:0]))
		else $error("enable mask not written");

	a_gate_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(reg_wr && hit_gate) |=> line_gate_control_ff == $past(reg_wdata[1:0]))
		else $error("gate register not written");

	a_enable_keeps: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!(reg_wr && hit_enable) |=> $stable(event_enable_mask_ff))
		else $error("enable mask changed without a write");

	a_route_keeps: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!(reg_wr && hit_route) |=> $stable(event_line_route_ff))
		else $error("route register changed without a write");

	a_gate_keeps: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!(reg_wr && hit_gate) |=> $stable(line_gate_control_ff))
		else $error("gate register changed without a write");

	a_set_beats_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(rise[2] && clr_mask[2]) |=> event_flag_bits_ff[2])
		else $error("clear won over a same-cycle set");

	a_held_no_reset: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clr_mask[0] && event_cond[0] && cond_prev_ff[0]) |=> !event_flag_bits_ff[0])
		else $error("held condition set its flag again");

	a_flag_write_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clr_all && reg_wdata == 32'h00000000)
		|=> event_flag_bits_ff == ($past(event_flag_bits_ff) | $past(rise)))
		else $error("writing zero changed a flag");

	a_read_keeps: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(reg_rd && rise == '0) |=> event_flag_bits_ff == $past(event_flag_bits_ff))
		else $error("read changed the flags");

	a_reset_clears: assert property (@(posedge ref_clk)
		sys_rst |=> event_flag_bits_ff == '0 && !event_out_a && !event_out_b)
		else $error("reset left a flag or a line set");

	a_reset_config: assert property (@(posedge ref_clk)
		sys_rst |=> event_enable_mask_ff == '0 && event_line_route_ff == '0
		&& line_gate_control_ff == 2'h0)
		else $error("reset left configuration set");

	a_no_flag_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(event_flag_bits_ff == '0) |-> !event_out_a && !event_out_b)
		else $error("line asserted with no flag set");

	a_only_enabled: assert property (@(posedge ref_clk) disable iff (sys_rst)
		((event_flag_bits_ff & event_enable_mask_ff) == '0) |-> !event_out_a && !event_out_b)
		else $error("line asserted with no enabled flag");

	// ------------------------------------------------------------
	// Named flag checks
	// ------------------------------------------------------------
	a_rxq0_new_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rise[evt_router_pkg::BIT_RXQ0_NEW] |=> rxq0_new_flag)
		else $error("queue 0 new flag did not set");

	a_rxq0_level_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rise[evt_router_pkg::BIT_RXQ0_LEVEL] |=> rxq0_level_flag)
		else $error("queue 0 level flag did not set");

	a_rxq0_full_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rise[evt_router_pkg::BIT_RXQ0_FULL] |=> rxq0_full_flag)
		else $error("queue 0 full flag did not set");

	a_rxq0_lost_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rise[evt_router_pkg::BIT_RXQ0_LOST] |=> rxq0_lost_flag)
		else $error("queue 0 lost flag did not set");

	a_rxq1_new_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rise[evt_router_pkg::BIT_RXQ1_NEW] |=> rxq1_new_flag)
		else $error("queue 1 new flag did not set");

	a_rxq1_level_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rise[evt_router_pkg::BIT_RXQ1_LEVEL] |=> rxq1_level_flag)
		else $error("queue 1 level flag did not set");

	a_rxq1_full_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rise[evt_router_pkg::BIT_RXQ1_FULL] |=> rxq1_full_flag)
		else $error("queue 1 full flag did not set");

	a_rxq1_lost_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rise[evt_router_pkg::BIT_RXQ1_LOST] |=> rxq1_lost_flag)
		else $error("queue 1 lost flag did not set");

	a_urgent_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rise[evt_router_pkg::BIT_URGENT_MSG] |=> urgent_msg_flag)
		else $error("urgent message flag did not set");

	a_send_done_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rise[evt_router_pkg::BIT_SEND_DONE] |=> send_done_flag)
		else $error("send done flag did not set");

	a_cancel_done_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rise[evt_router_pkg::BIT_CANCEL_DONE] |=> cancel_done_flag)
		else $error("cancel done flag did not set");

	a_txq_empty_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rise[evt_router_pkg::BIT_TXQ_EMPTY] |=> txq_empty_flag)
		else $error("transmit queue empty flag did not set");

	a_txlog_new_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rise[evt_router_pkg::BIT_TXLOG_NEW] |=> txlog_new_flag)
		else $error("log new flag did not set");

	a_txlog_level_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rise[evt_router_pkg::BIT_TXLOG_LEVEL] |=> txlog_level_flag)
		else $error("log level flag did not set");

	a_txlog_full_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rise[evt_router_pkg::BIT_TXLOG_FULL] |=> txlog_full_flag)
		else $error("log full flag did not set");

	a_txlog_lost_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rise[evt_router_pkg::BIT_TXLOG_LOST] |=> txlog_lost_flag)
		else $error("log lost flag did not set");

	a_stamp_wrap_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rise[evt_router_pkg::BIT_STAMP_WRAP] |=> stamp_wrap_flag)
		else $error("timestamp wrap flag did not set");

endmodule

// file: evt_router_pkg.sv
// Constants shared by the event interrupt router.
// Assumes a single 100 MHz clock and a plain register port.
// How it works
// - Tx log lost flag, bit 15, on element loss or zero-size write.
// - Queue 1 lost flag, bit 7, on loss or zero-size write.
// - Queue 0 lost flag, bit 3, on loss or zero-size write.
// - Timestamp wrap flag, bit 16, on counter rollover.
// - Tx log full flag, bit 14, when log reaches capacity.
// - Tx log level flag, bit 13, when fill reaches watermark.
// - Tx log new flag, bit 12, on each log write.
// - Transmit queue empty flag, bit 11, when queue empties.
// - Cancel done flag, bit 10, when a cancellation completes.
// - Send done flag, bit 9, on successful transmission.
// - Urgent message flag, bit 8, on high priority reception.
// - Queue 1 full bit 6, level bit 5, new bit 4.
// - Queue 0 full bit 2, level bit 1, new bit 0.
// - A flag reaches a line only if its enable bit is 1.
// - Enable bits 29..0 read/write; bits 31..30 read zero.
// - Route bit 0 selects line 0, 1 selects line 1.
// - Route bits 29..0 read/write; upper two bits read zero.
// - A line asserts only when its own gate bit is set.
// - Flags set on rising condition, cleared by writing 1, reset clears.
// - Gate register bit 0 enables line 0, bit 1 line 1.
package evt_router_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned NUM_FLAGS = 30;
	localparam int unsigned BIT_RXQ0_NEW = 0;
	localparam int unsigned BIT_RXQ0_LEVEL = 1;
	localparam int unsigned BIT_RXQ0_FULL = 2;
	localparam int unsigned BIT_RXQ0_LOST = 3;
	localparam int unsigned BIT_RXQ1_NEW = 4;
	localparam int unsigned BIT_RXQ1_LEVEL = 5;
	localparam int unsigned BIT_RXQ1_FULL = 6;
	localparam int unsigned BIT_RXQ1_LOST = 7;
	localparam int unsigned BIT_URGENT_MSG = 8;
	localparam int unsigned BIT_SEND_DONE = 9;
	localparam int unsigned BIT_CANCEL_DONE = 10;
	localparam int unsigned BIT_TXQ_EMPTY = 11;
	localparam int unsigned BIT_TXLOG_NEW = 12;
	localparam int unsigned BIT_TXLOG_LEVEL = 13;
	localparam int unsigned BIT_TXLOG_FULL = 14;
	localparam int unsigned BIT_TXLOG_LOST = 15;
	localparam int unsigned BIT_STAMP_WRAP = 16;
	localparam logic [7:0] OFS_FLAG_BITS = 8'h50;
	localparam logic [7:0] OFS_ENABLE_MASK = 8'h54;
	localparam logic [7:0] OFS_LINE_ROUTE = 8'h58;
	localparam logic [7:0] OFS_LINE_GATE = 8'h5C;
	localparam int unsigned GATE_LINE0_BIT = 0;
	localparam int unsigned GATE_LINE1_BIT = 1;
	localparam logic [29:0] FLAGS_RST = 30'h00000000;
	localparam logic [29:0] ENABLE_RST = 30'h00000000;
	localparam logic [29:0] ROUTE_RST = 30'h00000000;
	localparam logic [1:0] GATE_RST = 2'h0;
endpackage

// file: host_irq_model.sv
// Host side of the two interrupt lines, sampled on the clock.
// Assumes both lines are active high levels.
`timescale 1ns/1ps
module host_irq_model (
	input wire logic ref_clk, // Clock
	input wire logic line_a, // Line 0 in
	input wire logic line_b, // Line 1 in
	output logic seen_a, // Sampled line 0
	output logic seen_b // Sampled line 1
);
	always_ff @(posedge ref_clk) begin
		seen_a <= line_a;
		seen_b <= line_b;
	end
endmodule

// file: test_can_event_irq_router.sv
// Self-checking bench for the event router.
// Assumes the router and the host model are compiled first.
`timescale 1ns/1ps
module test_can_event_irq_router;
	logic ref_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, rd_seen = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [29:0] event_cond = '0, rt;
	logic event_out_a, event_out_b, seen_a, seen_b, line_a_q = 0, line_b_q = 0;
	logic [31:0] exp_q[$];
	int n_errors = 0, total_checks = 0, seed = 32'hC3E4E015;
	always #5 ref_clk = ~ref_clk;
	can_event_irq_router i_can_event_irq_router (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .event_cond(event_cond), .event_out_a(event_out_a),
		.event_out_b(event_out_b));
	host_irq_model i_host_irq_model (.ref_clk(ref_clk), .line_a(event_out_a),
		.line_b(event_out_b), .seen_a(seen_a), .seen_b(seen_b));
	// --------------------------------
	// Tasks
	// --------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_rd <= 0;
		reg_wr <= 1;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_wr <= 0;
		reg_rd <= 1;
		exp_q.push_back(e);
		@(posedge ref_clk);
	endtask
	task automatic ev(input int i);
		reg_wr <= 0;
		reg_rd <= 0;
		event_cond[i] <= 1;
		@(posedge ref_clk);
		event_cond[i] <= 0;
	endtask
	task automatic ln(input logic a, input logic b);
		reg_wr <= 0;
		reg_rd <= 0;
		@(negedge ref_clk);
		chk("line_a", {31'h0, a}, {31'h0, event_out_a});
		chk("line_b", {31'h0, b}, {31'h0, event_out_b});
		@(posedge ref_clk);
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Read data monitor
	always @(posedge ref_clk) rd_seen <= reg_rd;
	always @(negedge ref_clk) begin
		if (rd_seen && exp_q.size() > 0)
			chk("rdata", exp_q.pop_front(), reg_rdata);
	end
	// Host model must show each line one edge late
	always @(posedge ref_clk) {line_a_q, line_b_q} <= {event_out_a, event_out_b};
	always @(negedge ref_clk) begin
		if (!sys_rst)
			chk("host_seen", {30'h0, line_a_q, line_b_q}, {30'h0, seen_a, seen_b});
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		n_errors++;
		print_verdict();
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		sys_rst <= 0;
		@(posedge ref_clk);
		for (int k = 0; k < 5; k++) rd(8'h50 + 8'(4 * k), 32'h0);
		wr(8'h54, 32'hFFFFFFFF);
		wr(8'h58, 32'hFFFFFFFF);
		wr(8'h5C, 32'hFFFFFFFF);
		rd(8'h54, 32'h3FFFFFFF);
		rd(8'h58, 32'h3FFFFFFF);
		rd(8'h5C, 32'h3);
		$display("test registers done");
		rt = 30'($random(seed));
		wr(8'h58, {2'b00, rt});
		for (int i = 0; i < 30; i++) begin
			ev(i);
			ln(!rt[i], rt[i]);
			rd(8'h50, 32'h1 << i);
			wr(8'h50, 32'h1 << i);
			ln(0, 0);
		end
		$display("test flags done");
		wr(8'h54, 32'h0);
		ev(5);
		ln(0, 0);
		wr(8'h54, 32'hFFFFFFFF);
		ln(!rt[5], rt[5]);
		wr(8'h5C, 32'h0);
		ln(0, 0);
		wr(8'h5C, 32'h1);
		ln(!rt[5], 0);
		wr(8'h50, 32'h0);
		rd(8'h50, 32'h20);
		reg_rd <= 0;
		repeat (3) @(posedge ref_clk);
		$display("test gating done");
		print_verdict();
	end
endmodule
